// ===== rtl/cmp_ctrl_pkg.sv
// Package: register map, field positions, reset values and codes of the comparator control block
package cmp_ctrl_pkg;

	// Register offsets in the special function register space
	localparam logic [7:0] CONTROL_ADDR      = 8'h9b;
	localparam logic [7:0] MODE_ADDR         = 8'h9d;
	localparam logic [7:0] INPUT_SELECT_ADDR = 8'h9f;

	// Reset values
	localparam logic [7:0] CONTROL_RESET      = 8'h00;
	localparam logic [7:0] MODE_RESET         = 8'h02;
	localparam logic [7:0] INPUT_SELECT_RESET = 8'hff;

	// Control register fields
	localparam int ON_BIT        = 7;
	localparam int STATE_BIT     = 6;
	localparam int RISE_FLAG_BIT = 5;
	localparam int FALL_FLAG_BIT = 4;
	localparam int UP_HYST_LSB   = 2;
	localparam int DOWN_HYST_LSB = 0;

	// Mode register fields
	localparam int RISE_MASK_BIT = 5;
	localparam int FALL_MASK_BIT = 4;
	localparam int RESP_LSB      = 0;

	// Input select register fields
	localparam int MINUS_SEL_LSB = 4;
	localparam int PLUS_SEL_LSB  = 0;
	localparam int SEL_NONE_BIT  = 3;

	// Hysteresis codes
	typedef enum logic [1:0] {
		HYST_OFF   = 2'b00,
		HYST_5MV   = 2'b01,
		HYST_10MV  = 2'b10,
		HYST_20MV  = 2'b11
	} hyst_sel_t;

	// Response time modes
	typedef enum logic [1:0] {
		RESP_FAST    = 2'b00,
		RESP_MEDIUM  = 2'b01,
		RESP_SLOW    = 2'b10,
		RESP_SLOWEST = 2'b11
	} resp_sel_t;

endpackage

// ===== rtl/cmp_sync.sv
// Two-flop synchroniser with edge detection on the synchronised sample
`timescale 1ns/1ps
module cmp_sync (
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	input  wire logic async_i,
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);
	logic meta_reg;
	logic meta_next;
	logic sync_reg;
	logic sync_next;
	logic prev_reg;
	logic prev_next;

	always_comb begin
		meta_next = meta_reg;
		sync_next = sync_reg;
		prev_next = prev_reg;
		if (ce_i) begin
			meta_next = async_i;
			sync_next = meta_reg;
			prev_next = sync_reg;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end

	// Edges compare successive synchronised samples only
	assign level_o = sync_reg;
	assign rise_o  = ce_i & sync_reg & ~prev_reg;
	assign fall_o  = ce_i & ~sync_reg & prev_reg;
endmodule // cmp_sync

// ===== rtl/cmp_ctrl.sv
// Comparator control: registers, edge flags, masks, input selects and output paths
// How it works
// - Enable bit switches comparator on or off
// - Read-only state bit shows comparator result
// - Rising output edge sets rise flag
// - Falling edge sets fall flag; software clears
// - Flags sticky until software writes zero
// - Upward hysteresis field: off, 5, 10, 20mV
// - Downward hysteresis field with same coding
// - Rise request equals rise mask and flag
// - Fall request equals fall mask and flag
// - Upper select nibble picks one of eight minus pins
// - Lower select nibble picks one of eight plus pins
// - Result offered latched and raw to pins
// - Raw output needs no clock
// - Disabled comparator drives pin output low
// - Result offered as reset source
// - Edge masks sit in mode register
// - Mode low bits pick response time
`timescale 1ns/1ps
module cmp_ctrl
	import cmp_ctrl_pkg::*;
(
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic [7:0] sfr_wdata_i,
	input  wire logic       sfr_wr_i,
	output logic      [7:0] sfr_rdata_o,
	input  wire logic       analog_result_i,
	output logic            comparator_on_o,
	output logic      [1:0] upward_hysteresis_sel_o,
	output logic      [1:0] downward_hysteresis_sel_o,
	output logic      [1:0] response_time_sel_o,
	output logic      [3:0] minus_input_sel_o,
	output logic      [3:0] plus_input_sel_o,
	output logic      [7:0] minus_pin_en_o,
	output logic      [7:0] plus_pin_en_o,
	output logic            latched_result_out_o,
	output logic            raw_result_out_o,
	output logic            reset_source_o,
	output logic            rise_irq_o,
	output logic            fall_irq_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Decoding

	// One-hot pin enable; a code with the top bit set connects nothing
	function automatic logic [7:0] pin_decode(input logic [3:0] code);
		logic [7:0] onehot;
		onehot = 8'h00;
		if (!code[SEL_NONE_BIT])
			onehot[code[2:0]] = 1'b1;
		return onehot;
	endfunction

	logic wr_ctrl;
	logic wr_mode;
	logic wr_mux;
	assign wr_ctrl = ce_i & sfr_wr_i & (sfr_addr_i == CONTROL_ADDR);
	assign wr_mode = ce_i & sfr_wr_i & (sfr_addr_i == MODE_ADDR);
	assign wr_mux  = ce_i & sfr_wr_i & (sfr_addr_i == INPUT_SELECT_ADDR);

	////////////////////////////////////////////////////////////////////////////////
	// Result path

	logic gated_result;
	logic sync_level;
	logic rise_evt;
	logic fall_evt;

	// Unclocked gate so the raw output keeps working with the clock stopped
	// A switch-off drops the gated level, so it may set the fall flag as well
	assign gated_result     = analog_result_i & comparator_on_o;
	assign raw_result_out_o = gated_result;
	assign reset_source_o   = gated_result;

	cmp_sync u_sync (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.ce_i       (ce_i),
		.async_i    (gated_result),
		.level_o    (sync_level),
		.rise_o     (rise_evt),
		.fall_o     (fall_evt)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	logic       on_reg;
	logic       on_next;
	logic       rise_flag_reg;
	logic       rise_flag_next;
	logic       fall_flag_reg;
	logic       fall_flag_next;
	logic [1:0] up_hyst_reg;
	logic [1:0] up_hyst_next;
	logic [1:0] down_hyst_reg;
	logic [1:0] down_hyst_next;
	logic       rise_mask_reg;
	logic       rise_mask_next;
	logic       fall_mask_reg;
	logic       fall_mask_next;
	logic [1:0] resp_reg;
	logic [1:0] resp_next;
	logic [7:0] mux_reg;
	logic [7:0] mux_next;
	logic       latched_reg;
	logic       latched_next;

	always_comb begin
		on_next        = on_reg;
		rise_flag_next = rise_flag_reg;
		fall_flag_next = fall_flag_reg;
		up_hyst_next   = up_hyst_reg;
		down_hyst_next = down_hyst_reg;
		rise_mask_next = rise_mask_reg;
		fall_mask_next = fall_mask_reg;
		resp_next      = resp_reg;
		mux_next       = mux_reg;
		latched_next   = latched_reg;
		if (wr_ctrl) begin
			on_next        = sfr_wdata_i[ON_BIT];
			up_hyst_next   = sfr_wdata_i[UP_HYST_LSB +: 2];
			down_hyst_next = sfr_wdata_i[DOWN_HYST_LSB +: 2];
			// Only a zero clears; a one leaves the flag as it is
			if (!sfr_wdata_i[RISE_FLAG_BIT])
				rise_flag_next = 1'b0;
			if (!sfr_wdata_i[FALL_FLAG_BIT])
				fall_flag_next = 1'b0;
		end
		// Hardware set wins over a clear in the same cycle
		if (rise_evt)
			rise_flag_next = 1'b1;
		if (fall_evt)
			fall_flag_next = 1'b1;
		if (wr_mode) begin
			rise_mask_next = sfr_wdata_i[RISE_MASK_BIT];
			fall_mask_next = sfr_wdata_i[FALL_MASK_BIT];
			resp_next      = sfr_wdata_i[RESP_LSB +: 2];
		end
		if (wr_mux)
			mux_next = sfr_wdata_i;
		// Gated by the next enable so the pin drops in the cycle of the switch-off
		if (ce_i)
			latched_next = sync_level & on_next;
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			on_reg        <= CONTROL_RESET[ON_BIT];
			rise_flag_reg <= CONTROL_RESET[RISE_FLAG_BIT];
			fall_flag_reg <= CONTROL_RESET[FALL_FLAG_BIT];
			up_hyst_reg   <= CONTROL_RESET[UP_HYST_LSB +: 2];
			down_hyst_reg <= CONTROL_RESET[DOWN_HYST_LSB +: 2];
			rise_mask_reg <= MODE_RESET[RISE_MASK_BIT];
			fall_mask_reg <= MODE_RESET[FALL_MASK_BIT];
			resp_reg      <= MODE_RESET[RESP_LSB +: 2];
			mux_reg       <= INPUT_SELECT_RESET;
			latched_reg   <= 1'b0;
		end else begin
			on_reg        <= on_next;
			rise_flag_reg <= rise_flag_next;
			fall_flag_reg <= fall_flag_next;
			up_hyst_reg   <= up_hyst_next;
			down_hyst_reg <= down_hyst_next;
			rise_mask_reg <= rise_mask_next;
			fall_mask_reg <= fall_mask_next;
			resp_reg      <= resp_next;
			mux_reg       <= mux_next;
			latched_reg   <= latched_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs and read-back

	assign comparator_on_o           = on_reg;
	assign upward_hysteresis_sel_o   = up_hyst_reg;
	assign downward_hysteresis_sel_o = down_hyst_reg;
	assign response_time_sel_o       = resp_reg;
	assign minus_input_sel_o         = mux_reg[MINUS_SEL_LSB +: 4];
	assign plus_input_sel_o          = mux_reg[PLUS_SEL_LSB +: 4];
	assign minus_pin_en_o            = pin_decode(mux_reg[MINUS_SEL_LSB +: 4]);
	assign plus_pin_en_o             = pin_decode(mux_reg[PLUS_SEL_LSB +: 4]);
	assign latched_result_out_o      = latched_reg;
	assign rise_irq_o                = rise_mask_reg & rise_flag_reg;
	assign fall_irq_o                = fall_mask_reg & fall_flag_reg;

	// Read data is combinational from the registers; the state bit is live
	always_comb begin
		sfr_rdata_o = 8'h00;
		case (sfr_addr_i)
			CONTROL_ADDR: begin
				sfr_rdata_o = {on_reg, sync_level, rise_flag_reg, fall_flag_reg,
					up_hyst_reg, down_hyst_reg};
			end
			MODE_ADDR: begin
				sfr_rdata_o = {2'b00, rise_mask_reg, fall_mask_reg, 2'b00, resp_reg};
			end
			INPUT_SELECT_ADDR: begin
				sfr_rdata_o = mux_reg;
			end
			default: begin
				sfr_rdata_o = 8'h00;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	a_rise_flag_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
		rise_evt |=> rise_flag_reg)
		else $error("rise flag not set after rising edge");

	a_fall_flag_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
		fall_evt |=> fall_flag_reg)
		else $error("fall flag not set after falling edge");

	a_flag_sticky: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(rise_flag_reg && !(wr_ctrl && !sfr_wdata_i[RISE_FLAG_BIT])) |=> rise_flag_reg)
		else $error("rise flag cleared without software write");

	a_flag_write_one: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(wr_ctrl && sfr_wdata_i[FALL_FLAG_BIT] && !fall_flag_reg && !fall_evt)
		|=> !fall_flag_reg)
		else $error("write of one set the fall flag");

	a_enable_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
		wr_ctrl |=> (comparator_on_o == $past(sfr_wdata_i[ON_BIT])))
		else $error("enable bit did not follow write");

	a_disabled_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(!comparator_on_o && ce_i) [*3] |=> !latched_result_out_o)
		else $error("latched output high while disabled");

	a_rise_irq: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(rise_evt && rise_mask_reg && !wr_mode) |=> rise_irq_o)
		else $error("rise request missing after enabled edge");

	a_fall_irq: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(fall_evt && fall_mask_reg && !wr_mode) |=> fall_irq_o)
		else $error("fall request missing after enabled edge");

	a_none_select: assert property (@(posedge core_clk_i) disable iff (rst_i)
		mux_reg[MINUS_SEL_LSB + SEL_NONE_BIT] |-> (minus_pin_en_o == 8'h00))
		else $error("minus pin connected with none code");

	a_mode_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
		wr_mode |=> (response_time_sel_o == $past(sfr_wdata_i[1:0])))
		else $error("response mode did not follow write");

	a_fall_sticky: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(fall_flag_reg && !(wr_ctrl && !sfr_wdata_i[FALL_FLAG_BIT])) |=> fall_flag_reg)
		else $error("fall flag cleared without software write");

	a_rise_write_one: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(wr_ctrl && sfr_wdata_i[RISE_FLAG_BIT] && !rise_flag_reg && !rise_evt)
		|=> !rise_flag_reg)
		else $error("write of one set the rise flag");

	a_rise_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(wr_ctrl && !sfr_wdata_i[RISE_FLAG_BIT] && !rise_evt)
		|=> !rise_flag_reg)
		else $error("rise flag not cleared by write of zero");

	a_fall_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(wr_ctrl && !sfr_wdata_i[FALL_FLAG_BIT] && !fall_evt)
		|=> !fall_flag_reg)
		else $error("fall flag not cleared by write of zero");

	a_plus_none: assert property (@(posedge core_clk_i) disable iff (rst_i)
		mux_reg[PLUS_SEL_LSB + SEL_NONE_BIT] |-> (plus_pin_en_o == 8'h00))
		else $error("plus pin connected with none code");

	a_off_latched_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!comparator_on_o |-> !latched_result_out_o)
		else $error("latched output high with enable off");

	a_mask_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
		wr_mode |=> (rise_mask_reg == $past(sfr_wdata_i[RISE_MASK_BIT])
			&& fall_mask_reg == $past(sfr_wdata_i[FALL_MASK_BIT])))
		else $error("edge masks did not follow write");

	a_hyst_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
		wr_ctrl |=> ({upward_hysteresis_sel_o, downward_hysteresis_sel_o}
			== $past(sfr_wdata_i[3:0])))
		else $error("hysteresis fields did not follow write");

	a_mux_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!wr_mux |=> $stable(mux_reg))
		else $error("input select changed without write");

	a_reset_mode: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$fell(rst_i) |-> (response_time_sel_o == MODE_RESET[RESP_LSB +: 2]
			&& mux_reg == INPUT_SELECT_RESET))
		else $error("mode or select not at reset value");

endmodule // cmp_ctrl

// ===== bench/analog_front.sv
// Analog front model: compares the selected plus and minus pin voltages
`timescale 1ns/1ps
module analog_front (
	input  wire logic [15:0] plus_mv_i,
	input  wire logic [15:0] minus_mv_i,
	output logic             result_o
);
	// Ideal comparator, no hysteresis: the digital block never sees the threshold
	always_comb result_o = plus_mv_i > minus_mv_i;
endmodule // analog_front

// ===== bench/tb.sv
// Testbench: comparator control registers, edge flags, masks and output paths
`timescale 1ns/1ps
module tb;
	import cmp_ctrl_pkg::*;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] r;} row_t;
	logic        core_clk_i = 1'b0;
	logic        rst_i      = 1'b1;
	logic        ce_i       = 1'b1;
	logic        sfr_wr_i   = 1'b0;
	logic [7:0]  sfr_addr_i = 8'h00;
	logic [7:0]  sfr_wdata_i = 8'h00;
	logic [15:0] plus_mv    = 16'h0064;
	logic [15:0] minus_mv   = 16'h00c8;
	logic [7:0]  sfr_rdata_o, minus_pin_en_o, plus_pin_en_o, exp;
	logic [3:0]  minus_input_sel_o, plus_input_sel_o;
	logic [1:0]  upward_hysteresis_sel_o, downward_hysteresis_sel_o, response_time_sel_o;
	logic        analog_result_i, comparator_on_o, latched_result_out_o, raw_result_out_o;
	logic        reset_source_o, rise_irq_o, fall_irq_o;
	int          error_cnt = 0;
	int          n_tests = 0;
	row_t rows[8] = '{'{8'h9b, 8'hff, 8'h8f}, '{8'h9b, 8'h05, 8'h05}, '{8'h9b, 8'h0a, 8'h0a},
		'{8'h9d, 8'hff, 8'h33}, '{8'h9d, 8'hcc, 8'h00}, '{8'h9f, 8'ha5, 8'ha5},
		'{8'h9f, 8'h78, 8'h78}, '{8'h9c, 8'hff, 8'h00}};

	cmp_ctrl u_cmp_ctrl (.core_clk_i, .rst_i, .ce_i, .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i,
		.sfr_rdata_o, .analog_result_i, .comparator_on_o, .upward_hysteresis_sel_o,
		.downward_hysteresis_sel_o, .response_time_sel_o, .minus_input_sel_o,
		.plus_input_sel_o, .minus_pin_en_o, .plus_pin_en_o, .latched_result_out_o,
		.raw_result_out_o, .reset_source_o, .rise_irq_o, .fall_irq_o);
	analog_front u_analog_front (.plus_mv_i(plus_mv), .minus_mv_i(minus_mv),
		.result_o(analog_result_i));

	always #2.5 core_clk_i = ~core_clk_i;

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	// Address stays on the bus afterwards so the read-back is combinational
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk_i);
		sfr_addr_i = a;
		sfr_wdata_i = d;
		sfr_wr_i = 1'b1;
		@(negedge core_clk_i);
		sfr_wr_i = 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge core_clk_i);
		sfr_addr_i = a;
		#1 chk("rdata", e, sfr_rdata_o);
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#20000;
		error_cnt++;
		stop_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge core_clk_i);
		@(negedge core_clk_i) rst_i = 1'b0;
		rd(CONTROL_ADDR, 8'h00);
		rd(MODE_ADDR, 8'h02);
		rd(INPUT_SELECT_ADDR, 8'hff);
		chk("irqs", 8'h00, {6'h0, rise_irq_o, fall_irq_o});
		$display("test reset done");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			chk("rdata", rows[i].r, sfr_rdata_o);
			if (rows[i].a == CONTROL_ADDR)
				chk("hyst", {4'h0, rows[i].r[3:0]}, {4'h0, upward_hysteresis_sel_o,
					downward_hysteresis_sel_o});
			if (rows[i].a == MODE_ADDR)
				chk("resp", {6'h0, rows[i].r[1:0]}, {6'h0, response_time_sel_o});
		end
		$display("test register rows done");
		for (int c = 0; c < 16; c++) begin
			// Plus code is the inverse of the minus code so swapped nibbles show up
			wr(INPUT_SELECT_ADDR, {c[3:0], ~c[3:0]});
			exp = c[3] ? 8'h00 : 8'h01 << c[2:0];
			chk("minus_en", exp, minus_pin_en_o);
			chk("minus_sel", {4'h0, c[3:0]}, {4'h0, minus_input_sel_o});
			exp = c[3] ? 8'h01 << ~c[2:0] : 8'h00;
			chk("plus_en", exp, plus_pin_en_o);
			chk("plus_sel", {4'h0, ~c[3:0]}, {4'h0, plus_input_sel_o});
		end
		ce_i = 1'b0;
		wr(INPUT_SELECT_ADDR, 8'h11);
		chk("ce_hold", 8'hf0, sfr_rdata_o);
		ce_i = 1'b1;
		$display("test input select done");
		wr(MODE_ADDR, 8'h30);
		wr(CONTROL_ADDR, 8'h80);
		repeat (4) @(negedge core_clk_i);
		// Settling edges after switch-on are discarded before real traffic
		wr(CONTROL_ADDR, 8'h80);
		plus_mv = 16'h012c;
		#1 chk("raw", 8'h01, {7'h0, raw_result_out_o});
		repeat (3) @(posedge core_clk_i);
		#1 chk("rdata", 8'he0, sfr_rdata_o);
		chk("latched", 8'h01, {7'h0, latched_result_out_o});
		chk("rise_irq", 8'h01, {7'h0, rise_irq_o});
		chk("rst_src", 8'h01, {7'h0, reset_source_o});
		wr(CONTROL_ADDR, 8'hb0);
		chk("rdata", 8'he0, sfr_rdata_o);
		wr(CONTROL_ADDR, 8'h80);
		chk("rdata", 8'hc0, sfr_rdata_o);
		chk("rise_irq", 8'h00, {7'h0, rise_irq_o});
		plus_mv = 16'h0064;
		repeat (3) @(posedge core_clk_i);
		#1 chk("rdata", 8'h90, sfr_rdata_o);
		chk("fall_irq", 8'h01, {7'h0, fall_irq_o});
		wr(MODE_ADDR, 8'h00);
		chk("fall_irq", 8'h00, {7'h0, fall_irq_o});
		$display("test edges done");
		// Clock enable low stands in for a stopped clock: only the raw path may move
		ce_i = 1'b0;
		plus_mv = 16'h012c;
		repeat (3) @(posedge core_clk_i);
		#1 chk("raw_frozen", 8'h01, {7'h0, raw_result_out_o});
		chk("latched_frozen", 8'h00, {7'h0, latched_result_out_o});
		@(negedge core_clk_i) ce_i = 1'b1;
		repeat (3) @(posedge core_clk_i);
		#1 chk("latched", 8'h01, {7'h0, latched_result_out_o});
		$display("test frozen clock done");
		wr(CONTROL_ADDR, 8'h00);
		chk("raw_off", 8'h00, {7'h0, raw_result_out_o});
		chk("latched_off", 8'h00, {7'h0, latched_result_out_o});
		repeat (4) @(posedge core_clk_i);
		#1 chk("latched_off", 8'h00, {7'h0, latched_result_out_o});
		chk("on", 8'h00, {7'h0, comparator_on_o});
		$display("test disable done");
		stop_test();
	end
endmodule // tb
